// *** tcsu_map.vh ***
// Register offsets, field positions, header offsets and reset values of the checksum engine
`ifndef TCSU_MAP_VH
`define TCSU_MAP_VH

`define TCSU_CTRL_OFF 12'h000
`define TCSU_LENS_OFF 12'h004
`define TCSU_MSS_OFF 12'h008
`define TCSU_TOTAL_PAYLOAD_LEN_OFF 12'h00c
`define TCSU_STATUS_OFF 12'h010
`define TCSU_CSUM_OFF 12'h014

`define TCSU_CTRL_START 0
`define TCSU_CTRL_SEG 1
`define TCSU_CTRL_IPV4 2
`define TCSU_CTRL_L4T 3
`define TCSU_CTRL_IPINS 4
`define TCSU_CTRL_L4INS 5
`define TCSU_CTRL_WRAP15 6
`define TCSU_CTRL_SNAP 7
`define TCSU_CTRL_FCS 8

`define TCSU_LENS_L2_LSB 0
`define TCSU_LENS_L3_LSB 8
`define TCSU_LENS_L4_LSB 24

`define TCSU_CTRL_RST 9'h000
`define TCSU_L2_RST 7'h0e
`define TCSU_L3_RST 9'h014
`define TCSU_L4_RST 8'h14
`define TCSU_MSS_RST 16'h05b4
`define TCSU_TOTAL_PAYLOAD_LEN_RST 18'h00000

`define TCSU_SNAP_LEN_OFF 16'h000c
`define TCSU_L2_BIAS 16'h000e
`define TCSU_V4_TOTLEN_OFF 16'h0002
`define TCSU_V4_ID_OFF 16'h0004
`define TCSU_V4_PROTO_OFF 16'h0009
`define TCSU_V4_CSUM_OFF 16'h000a
`define TCSU_V6_TOTAL_PAYLOAD_LEN_OFF 16'h0004
`define TCSU_V6_NEXT_OFF 16'h0006
`define TCSU_V6_BASE_LEN 16'h0028
`define TCSU_TCP_SEQ_OFF 16'h0004
`define TCSU_TCP_FLAGS_OFF 16'h000d
`define TCSU_TCP_CSUM_OFF 16'h0010
`define TCSU_UDP_LEN_OFF 16'h0004
`define TCSU_UDP_CSUM_OFF 16'h0006
`define TCSU_FIN_PSH_MASK 8'h09
`define TCSU_PROTO_TCP 8'h06
`define TCSU_PROTO_UDP 8'h11

`endif

// *** tcsu_engine.v ***
// Transmit checksum insertion and segmentation header update engine with APB registers
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tcsu_map.vh"

// Functional notes
// - Checksums are 16-bit one's complement sums accumulated as bytes stream in.
// - Field gets complement of sum from start to end, field's old content included.
// - At most one IP and one L4 checksum per frame; software does extra IP headers.
// - No IP checksum for IPv6; no L4 checksum unless protocol is TCP or UDP.
// - Long frames, VLAN tags and header options are handled like any other bytes.
// - Prototype header fetched once into 240-byte buffer, patched per derived frame.
// - SNAP type/length equals payload plus all header lengths minus 14.
// - IPv4 total length is payload plus L4 and L3 lengths; last frame uses remainder.
// - IPv6 payload length is payload plus L4 and L3 lengths minus 0x28.
// - IPv4 identification increments after the first frame, wrapping at 15 or 16 bits.
// - First frame keeps sequence number; later ones add previous payload size.
// - FIN and PSH cleared in first and middle frames, kept set in last frame.
// - Last payload is total minus segment size times frames sent; UDP length follows.
// - Without segmentation only the checksum fields change.
// - IP and L4 checksum insertion are enabled independently by their own bits.
// - IPv4 type flag set with IP insertion bit inserts IP header checksum; clear inserts none.
// - IPv4 checksum covers L2 length to end of L3 header, stored at L2 plus 10.
// - TCP checksum at L2+L3+16, UDP checksum at L2+L3+6, chosen by L4 type flag.
// - L4 checksum runs from L2+L3 to the last byte of the packet data.
// - During segmentation each frame's L4 length is added into the pseudo-header sum.
// - L4 checksum field is untouched unless the L4 insertion bit is set.
module tcsu_engine #(
    parameter FRAME_AW = 11,
    parameter HDR_DEPTH = 240
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire in_valid,
    output wire in_ready,
    input wire [7:0] in_data,
    input wire in_last,
    output wire out_valid,
    input wire out_ready,
    output wire [7:0] out_data,
    output wire out_last,
    output wire tx_fcs_append_en
);

    localparam ST_IDLE = 3'd0;
    localparam ST_CAP = 3'd1;
    localparam ST_HWR = 3'd2;
    localparam ST_PAY = 3'd3;
    localparam ST_SEND = 3'd4;

    function [7:0] fld;
        input [15:0] i;
        input [15:0] off;
        input [15:0] v;
        input [7:0] d;
        begin
            if (i == off)
                fld = v[15:8];
            else if (i == off + 16'h0001)
                fld = v[7:0];
            else
                fld = d;
        end
    endfunction

    // Byte weight depends on parity relative to the range start, so odd header lengths work
    function [31:0] contrib;
        input [15:0] i;
        input [15:0] lo;
        input [15:0] hi;
        input [7:0] b;
        begin
            if (i >= lo && i < hi)
                contrib = (i[0] ^ lo[0]) ? {24'h000000, b} : {16'h0000, b, 8'h00};
            else
                contrib = 32'h00000000;
        end
    endfunction

    function [15:0] fold;
        input [31:0] s;
        reg [16:0] t;
        reg [16:0] u;
        begin
            t = {1'b0, s[15:0]} + {1'b0, s[31:16]};
            u = {1'b0, t[15:0]} + {16'h0000, t[16]};
            fold = ~u[15:0];
        end
    endfunction

    reg [2:0] st_q;
    reg [8:0] ctrl_q;
    reg [6:0] l2_q;
    reg [8:0] l3_q;
    reg [7:0] l4_q;
    reg [15:0] mss_q;
    reg [17:0] total_payload_len_q;
    reg [15:0] idx_q;
    reg [15:0] rd_q;
    reg [15:0] flen_q;
    reg [15:0] pcnt_q;
    reg [17:0] rem_q;
    reg [15:0] frames_q;
    reg [15:0] id_q;
    reg [31:0] seq_q;
    reg [7:0] proto_q;
    reg [31:0] ips_q;
    reg [31:0] l4s_q;
    reg [7:0] out_data_q;
    reg out_valid_q;
    reg out_last_q;
    reg [31:0] lastcs_q;
    reg [31:0] prdata_q;
    reg pslverr_q;
    reg [7:0] hdr_buf [0:HDR_DEPTH-1];
    reg [7:0] fmem [0:(1<<FRAME_AW)-1];
    reg [7:0] hmod;
    reg [7:0] osub;
    reg [31:0] rd_mux;
    reg rd_err;

    wire seg = ctrl_q[`TCSU_CTRL_SEG];
    wire v4 = ctrl_q[`TCSU_CTRL_IPV4];
    wire l4t = ctrl_q[`TCSU_CTRL_L4T];
    wire ipins = ctrl_q[`TCSU_CTRL_IPINS];
    wire l4ins = ctrl_q[`TCSU_CTRL_L4INS];
    wire wrap15 = ctrl_q[`TCSU_CTRL_WRAP15];
    wire snap = ctrl_q[`TCSU_CTRL_SNAP];
    wire busy = (st_q != ST_IDLE);

    wire [15:0] o_ip = {9'h000, l2_q};
    wire [15:0] o_l4 = o_ip + {7'h00, l3_q};
    wire [15:0] hlen = o_l4 + {8'h00, l4_q};
    wire [15:0] o_proto = o_ip + (v4 ? `TCSU_V4_PROTO_OFF : `TCSU_V6_NEXT_OFF);
    wire last_frm = (rem_q <= {2'b00, mss_q});
    wire [15:0] pay = last_frm ? rem_q[15:0] : mss_q;
    wire [15:0] snap_len = pay + hlen - `TCSU_L2_BIAS;
    wire [15:0] ip_tot = pay + {8'h00, l4_q} + {7'h00, l3_q};
    wire [15:0] v6_len = ip_tot - `TCSU_V6_BASE_LEN;
    wire [15:0] l4_len = pay + {8'h00, l4_q};
    wire ip_do = v4 & ipins;
    wire proto_ok = (proto_q == `TCSU_PROTO_TCP) || (proto_q == `TCSU_PROTO_UDP);
    wire l4_do = l4ins & proto_ok;
    wire [15:0] ip_res = fold(ips_q);
    wire [31:0] l4_tot = l4s_q + (seg ? {16'h0000, l4_len} : 32'h00000000);
    wire [15:0] l4_raw = fold(l4_tot);
    // Zero is reserved for a missing UDP checksum, so a zero result goes out as all ones
    wire [15:0] l4_res = (!l4t && l4_raw == 16'h0000) ? 16'hffff : l4_raw;
    wire [15:0] l4_csum_off = o_l4 + (l4t ? `TCSU_TCP_CSUM_OFF : `TCSU_UDP_CSUM_OFF);

    wire in_acc = in_valid && (st_q == ST_CAP || st_q == ST_PAY);
    wire wr_en = (st_q == ST_HWR) || (st_q == ST_PAY && in_valid);
    wire [7:0] wr_byte = (st_q == ST_HWR) ? hmod : in_data;
    wire cap_pass = (st_q == ST_CAP) || (st_q == ST_PAY && !seg);
    wire pay_end = seg ? (pcnt_q == pay - 16'h0001) : in_last;
    wire can_load = (st_q == ST_SEND) && (!out_valid_q || out_ready) && (rd_q < flen_q);
    wire frm_done = out_valid_q && out_ready && out_last_q;
    wire apb_wr = psel && penable && pwrite;
    wire [15:0] id_inc = id_q + 16'h0001;

    assign in_ready = (st_q == ST_CAP) || (st_q == ST_PAY);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;
    assign out_last = out_last_q;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign tx_fcs_append_en = ctrl_q[`TCSU_CTRL_FCS];

    // Per-frame header patch applied while the prototype is copied into the frame store
    always @* begin
        hmod = hdr_buf[idx_q[7:0]];
        if (snap)
            hmod = fld(idx_q, `TCSU_SNAP_LEN_OFF, snap_len, hmod);
        if (v4) begin
            hmod = fld(idx_q, o_ip + `TCSU_V4_TOTLEN_OFF, ip_tot, hmod);
            hmod = fld(idx_q, o_ip + `TCSU_V4_ID_OFF, id_q, hmod);
        end else begin
            hmod = fld(idx_q, o_ip + `TCSU_V6_TOTAL_PAYLOAD_LEN_OFF, v6_len, hmod);
        end
        if (l4t) begin
            hmod = fld(idx_q, o_l4 + `TCSU_TCP_SEQ_OFF, seq_q[31:16], hmod);
            hmod = fld(idx_q, o_l4 + `TCSU_TCP_SEQ_OFF + 16'h0002, seq_q[15:0], hmod);
            if (idx_q == o_l4 + `TCSU_TCP_FLAGS_OFF && !last_frm)
                hmod = hmod & ~`TCSU_FIN_PSH_MASK;
        end else begin
            hmod = fld(idx_q, o_l4 + `TCSU_UDP_LEN_OFF, l4_len, hmod);
        end
    end

    // Only the checksum bytes are replaced on the way out
    always @* begin
        osub = fmem[rd_q[FRAME_AW-1:0]];
        if (ip_do)
            osub = fld(rd_q, o_ip + `TCSU_V4_CSUM_OFF, ip_res, osub);
        if (l4_do)
            osub = fld(rd_q, l4_csum_off, l4_res, osub);
    end

    always @* begin
        rd_err = 1'b0;
        rd_mux = 32'h00000000;
        if (paddr == `TCSU_CTRL_OFF) begin
            rd_mux = {23'h000000, ctrl_q[8:1], 1'b0};
        end else if (paddr == `TCSU_LENS_OFF) begin
            rd_mux = {l4_q, 7'h00, l3_q, 1'b0, l2_q};
        end else if (paddr == `TCSU_MSS_OFF) begin
            rd_mux = {16'h0000, mss_q};
        end else if (paddr == `TCSU_TOTAL_PAYLOAD_LEN_OFF) begin
            rd_mux = {14'h0000, total_payload_len_q};
        end else if (paddr == `TCSU_STATUS_OFF) begin
            rd_mux = {frames_q, 15'h0000, busy};
        end else if (paddr == `TCSU_CSUM_OFF) begin
            rd_mux = lastcs_q;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Read data is latched in the setup cycle so the zero-wait access phase sees a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= rd_err;
        end
    end

    // Context registers are frozen while a context runs, to keep the header patch coherent
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TCSU_CTRL_RST;
            l2_q <= `TCSU_L2_RST;
            l3_q <= `TCSU_L3_RST;
            l4_q <= `TCSU_L4_RST;
            mss_q <= `TCSU_MSS_RST;
            total_payload_len_q <= `TCSU_TOTAL_PAYLOAD_LEN_RST;
        end else if (apb_wr && !busy) begin
            if (paddr == `TCSU_CTRL_OFF) begin
                ctrl_q <= {pwdata[8:1], 1'b0};
            end else if (paddr == `TCSU_LENS_OFF) begin
                l2_q <= pwdata[`TCSU_LENS_L2_LSB+6:`TCSU_LENS_L2_LSB];
                l3_q <= pwdata[`TCSU_LENS_L3_LSB+8:`TCSU_LENS_L3_LSB];
                l4_q <= pwdata[`TCSU_LENS_L4_LSB+7:`TCSU_LENS_L4_LSB];
            end else if (paddr == `TCSU_MSS_OFF) begin
                mss_q <= pwdata[15:0];
            end else if (paddr == `TCSU_TOTAL_PAYLOAD_LEN_OFF) begin
                total_payload_len_q <= pwdata[17:0];
            end
        end
    end

    always @(posedge pclk) begin
        if (st_q == ST_CAP && in_valid)
            hdr_buf[idx_q[7:0]] <= in_data;
        if (wr_en)
            fmem[idx_q[FRAME_AW-1:0]] <= wr_byte;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            idx_q <= 16'h0000;
            rd_q <= 16'h0000;
            flen_q <= 16'h0000;
            pcnt_q <= 16'h0000;
            rem_q <= 18'h00000;
            frames_q <= 16'h0000;
            id_q <= 16'h0000;
            seq_q <= 32'h00000000;
            proto_q <= 8'h00;
            ips_q <= 32'h00000000;
            l4s_q <= 32'h00000000;
            out_data_q <= 8'h00;
            out_valid_q <= 1'b0;
            out_last_q <= 1'b0;
            lastcs_q <= 32'h00000000;
        end else begin
            // Sums run on the bytes as they enter the frame store, patched header included
            if (wr_en) begin
                ips_q <= ips_q + contrib(idx_q, o_ip, o_l4, wr_byte);
                l4s_q <= l4s_q + contrib(idx_q, o_l4, 16'hffff, wr_byte);
                idx_q <= idx_q + 16'h0001;
            end
            if (cap_pass && in_acc) begin
                if (idx_q == o_proto)
                    proto_q <= in_data;
                if (v4 && (idx_q == o_ip + `TCSU_V4_ID_OFF ||
                           idx_q == o_ip + `TCSU_V4_ID_OFF + 16'h0001))
                    id_q <= {id_q[7:0], in_data};
                if (idx_q >= o_l4 + `TCSU_TCP_SEQ_OFF && idx_q < o_l4 + `TCSU_TCP_SEQ_OFF + 16'h0004)
                    seq_q <= {seq_q[23:0], in_data};
            end
            if (can_load) begin
                out_data_q <= osub;
                out_valid_q <= 1'b1;
                out_last_q <= (rd_q == flen_q - 16'h0001);
                rd_q <= rd_q + 16'h0001;
            end else if (out_valid_q && out_ready) begin
                out_valid_q <= 1'b0;
                out_last_q <= 1'b0;
            end
            case (st_q)
                ST_IDLE: begin
                    if (apb_wr && paddr == `TCSU_CTRL_OFF && pwdata[`TCSU_CTRL_START]) begin
                        st_q <= pwdata[`TCSU_CTRL_SEG] ? ST_CAP : ST_PAY;
                        idx_q <= 16'h0000;
                        pcnt_q <= 16'h0000;
                        rem_q <= total_payload_len_q;
                        frames_q <= 16'h0000;
                        ips_q <= 32'h00000000;
                        l4s_q <= 32'h00000000;
                    end
                end
                ST_CAP: begin
                    if (in_valid) begin
                        idx_q <= idx_q + 16'h0001;
                        if (idx_q == hlen - 16'h0001) begin
                            st_q <= ST_HWR;
                            idx_q <= 16'h0000;
                        end
                    end
                end
                ST_HWR: begin
                    if (idx_q == hlen - 16'h0001) begin
                        st_q <= ST_PAY;
                        pcnt_q <= 16'h0000;
                    end
                end
                ST_PAY: begin
                    if (in_valid) begin
                        pcnt_q <= pcnt_q + 16'h0001;
                        if (pay_end) begin
                            st_q <= ST_SEND;
                            flen_q <= idx_q + 16'h0001;
                            rd_q <= 16'h0000;
                        end
                    end
                end
                ST_SEND: begin
                    if (frm_done) begin
                        lastcs_q <= {ip_res, l4_res};
                        frames_q <= frames_q + 16'h0001;
                        ips_q <= 32'h00000000;
                        l4s_q <= 32'h00000000;
                        idx_q <= 16'h0000;
                        if (seg && !last_frm) begin
                            st_q <= ST_HWR;
                            id_q <= wrap15 ? {1'b0, id_inc[14:0]} : id_inc;
                            seq_q <= seq_q + {16'h0000, pay};
                            rem_q <= rem_q - {2'b00, mss_q};
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // tcsu_engine

// *** tcsu_assertions.sv ***
// Port-level assertions for the checksum insertion and segmentation engine
`timescale 1ns/1ps
module tcsu_assertions (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire in_valid,
    input wire in_ready,
    input wire in_last,
    input wire out_valid,
    input wire out_ready,
    input wire [7:0] out_data,
    input wire out_last
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid
        && $stable(out_data) && $stable(out_last)) else $error("output byte lost under stall");
    AST_FALL_AFTER_LAST: assert property ($fell(out_valid) |->
        $past(out_ready) && $past(out_last)) else $error("frame cut short");
    AST_SEND_BLOCKS_IN: assert property (out_valid |-> !in_ready)
        else $error("input taken while a frame is sent");
    AST_FRAME_GAP: assert property (out_valid && out_ready && out_last |=> !out_valid)
        else $error("no gap after final byte");
    AST_SEND_START: assert property (in_valid && in_ready && in_last |=> !in_ready ##1 out_valid)
        else $error("frame did not start after its last input byte");
    AST_PREADY_HIGH: assert property (pready)
        else $error("wait state inserted");
    AST_ERR_UNMAPPED: assert property (psel && !penable && paddr > 12'h014 |=>
        pslverr && prdata == 32'h0) else $error("unmapped read not flagged");
    AST_OK_MAPPED: assert property (psel && !penable && paddr <= 12'h014 |=> !pslverr)
        else $error("mapped access flagged as error");
    AST_RDATA_STANDS: assert property (!(psel && !penable) |=>
        $stable(prdata) && $stable(pslverr)) else $error("read data moved outside setup");
endmodule // tcsu_assertions

// *** tcsu_mac_sink.sv ***
// Transmit MAC side model that takes frame bytes, stalling in bursts when asked
`timescale 1ns/1ps
module tcsu_mac_sink (
    input wire pclk,
    input wire presetn,
    input wire slow,
    input wire out_valid,
    input wire [7:0] out_data,
    input wire out_last,
    output reg out_ready
);
    logic [7:0] got_q[$];
    int ends_q[$];
    logic [2:0] stall_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
            stall_q <= 3'h0;
        end else begin
            stall_q <= stall_q + 3'h1;
            // Bursts of four stalled edges force the engine to hold a byte a while
            out_ready <= !slow || stall_q[2];
            if (out_valid && out_ready) begin
                got_q.push_back(out_data);
                if (out_last) ends_q.push_back(got_q.size());
            end
        end
    end
endmodule // tcsu_mac_sink

// *** tb_top.sv ***
// Self-checking bench for the checksum insertion and segmentation engine
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic in_valid, in_ready, in_last, out_valid, out_ready, out_last, fcs_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] in_data, out_data;
    logic [7:0] pk[$], ex[$];
    int bad_count = 0;
    int tests_run = 0;
    tcsu_engine u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .in_last(in_last), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_last(out_last), .tx_fcs_append_en(fcs_en));
    tcsu_mac_sink u_mac (.pclk(pclk), .presetn(presetn), .slow(slow), .out_valid(out_valid),
        .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [15:0] osum(input int lo, input int hi, input logic [31:0] s);
        for (int i = lo; i < hi; i += 2)
            s = s + {ex[i], (i + 1 < hi) ? ex[i + 1] : 8'h00};
        s = s[15:0] + s[31:16];
        s = s[15:0] + s[31:16];
        return s[15:0];
    endfunction
    task automatic put16(input int o, input logic [15:0] v);
        ex[o] = v[15:8];
        ex[o + 1] = v[7:0];
    endtask
    task automatic push(input int n, input logic endp);
        for (int i = 0; i < n; i++) begin
            in_valid <= 1'b1;
            in_data <= pk[i];
            in_last <= endp && (i == n - 1);
            @(posedge pclk);
            for (int k = 0; in_ready !== 1'b1 && k < 2000; k++) @(posedge pclk);
        end
        in_valid <= 1'b0;
        in_last <= 1'b0;
    endtask
    task automatic drain(input int n);
        for (int k = 0; u_mac.got_q.size() < n && k < 5000; k++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk("out length", u_mac.got_q.size(), n);
        chk("frame end", u_mac.ends_q[u_mac.ends_q.size() - 1], n);
        for (int i = 0; i < n && i < u_mac.got_q.size(); i++) begin
            chk("out byte", u_mac.got_q[i], ex[i]);
        end
        u_mac.got_q.delete();
    endtask
    task automatic regs_reset();
        logic [31:0] r;
        logic e;
        logic [11:0] ad[6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h018};
        logic [31:0] rv[6] = '{32'h0, 32'h1400140e, 32'h5b4, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ad[i], 32'h0, r, e);
            chk("reset read", r, rv[i]);
            chk("read error", e, i == 5);
        end
    endtask
    task automatic plain(input logic [8:0] c, input logic [7:0] pr, input logic ipx,
                         input logic l4x, input int l2, input int l3);
        logic [31:0] r;
        logic e;
        int o4;
        o4 = l2 + l3;
        ex.delete();
        // Arbitrary bytes in the L4 field stand for the host's pseudo-header sum
        for (int i = 0; i < 60; i++) ex.push_back(8'(i * 7 + 3));
        ex[l2 + 6] = pr;
        ex[l2 + 9] = pr;
        put16(l2 + 10, 16'h0);
        pk = ex;
        if (ipx) put16(l2 + 10, ~osum(l2, o4, 0));
        if (l4x) put16(o4 + (c[3] ? 16 : 6), ~osum(o4, 60, 0));
        slow <= 1'b0;
        apb(1'b1, 12'h004, {8'h14, 7'h00, 9'(l3), 1'b0, 7'(l2)}, r, e);
        apb(1'b1, 12'h000, {23'h0, c}, r, e);
        push(60, 1'b1);
        drain(60);
        u_mac.ends_q.delete();
        chk("fcs enable", fcs_en, c[8]);
    endtask
    task automatic seg_run(input logic v6u);
        logic [31:0] r, sq;
        logic [15:0] ipc, l4c;
        logic e;
        int b, pay, lo;
        ex.delete();
        for (int i = 0; i < 74; i++) ex.push_back(8'(i * 5 + 1));
        ex[v6u ? 20 : 23] = v6u ? 8'h11 : 8'h06;
        ex[47] = 8'h19;
        put16(18, 16'h7fff);
        put16(24, 16'h0);
        put16(38, 16'hffff);
        put16(40, 16'hfffc);
        pk = ex;
        ex.delete();
        for (int k = 0; k < 3; k++) begin
            pay = (k < 2) ? 8 : 4;
            b = ex.size();
            for (int i = 0; i < 54; i++) ex.push_back(pk[i]);
            for (int i = 0; i < pay; i++) ex.push_back(pk[54 + 8 * k + i]);
            sq = 32'hfffffffc + 8 * k;
            put16(b + 12, 16'(pay + 54 - 14));
            if (v6u) begin
                put16(b + 18, 16'(pay + 20 + 20 - 40));
                put16(b + 38, 16'(pay + 20));
            end else begin
                put16(b + 16, 16'(pay + 20 + 20));
                put16(b + 18, 16'((32'h7fff + k) & 32'h7fff));
                put16(b + 38, sq[31:16]);
                put16(b + 40, sq[15:0]);
                if (k < 2) ex[b + 47] = pk[47] & 8'hf6;
            end
            ipc = ~osum(b + 14, b + 34, 0);
            if (!v6u) put16(b + 24, ipc);
            lo = v6u ? 40 : 50;
            l4c = ~osum(b + 34, b + 54 + pay, 32'(pay + 20));
            if (v6u && l4c == 16'h0000) l4c = 16'hffff;
            put16(b + lo, l4c);
        end
        apb(1'b1, 12'h008, 32'h8, r, e);
        apb(1'b1, 12'h00c, 32'd20, r, e);
        apb(1'b1, 12'h004, 32'h1400140e, r, e);
        slow <= 1'b1;
        apb(1'b1, 12'h000, v6u ? 32'h1f3 : 32'h1ff, r, e);
        push(74, 1'b0);
        drain(182);
        chk("frame count", u_mac.ends_q.size(), 3);
        chk("first end", u_mac.ends_q[0], 62);
        chk("second end", u_mac.ends_q[1], 124);
        u_mac.ends_q.delete();
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk("status", r, 32'h00030000);
        apb(1'b0, 12'h014, 32'h0, r, e);
        chk("last sums", r, {ipc, l4c});
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        give_verdict();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, in_valid, in_last, slow} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        in_data = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        regs_reset();
        plain(9'h13d, 8'h06, 1'b1, 1'b1, 14, 20);
        plain(9'h015, 8'h11, 1'b1, 1'b0, 14, 20);
        plain(9'h025, 8'h11, 1'b0, 1'b1, 14, 20);
        plain(9'h139, 8'h06, 1'b0, 1'b1, 14, 20);
        plain(9'h135, 8'h01, 1'b1, 1'b0, 14, 20);
        plain(9'h13d, 8'h06, 1'b1, 1'b1, 18, 24);
        seg_run(1'b0);
        seg_run(1'b1);
        give_verdict();
    end
endmodule // tb_top
bind tcsu_engine tcsu_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_last(in_last), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last));
